/* File: dtec_pkg.sv */
/*
 * Package for the dual timer/event counter: register offsets, control
 * field positions, mode codes, reset values and clock-rate constants.
 * Assumes a single 25 MHz system clock and an AHB-Lite register bus.
 */
package dtec_pkg;

    // ==========================================================
    // Register offsets (byte addresses, one word per register)
    // ==========================================================
    localparam logic [7:0] OFS_LO [2] = '{8'h00, 8'h08};
    localparam logic [7:0] OFS_HI [2] = '{8'h04, 8'h0c};
    localparam logic [7:0] OFS_CTL [2] = '{8'h10, 8'h14};

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_RUN = 4;
    localparam int CTL_EDGE = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_MASK [2] = '{8'hd8, 8'h10};

    // Mode field codes
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;

    // Reset values of counter state other than the preload, and the full count
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam logic [15:0] COUNT_FULL = 16'hffff;

    // ==========================================================
    // Clock rates
    // ==========================================================
    localparam int ACC_W = 26;
    localparam logic [ACC_W-1:0] SYS_HZ = 26'h17d7840;
    localparam logic [ACC_W-1:0] SLOW_HZ = 26'h0008000;
    localparam logic [1:0] FAST_DIV_LAST = 2'h3;

    // Pulse-width measurement states
    typedef enum logic [1:0] {
        PW_WAIT = 2'b01,
        PW_MEASURE = 2'b10
    } dtec_pw_e;

endpackage

/* File: dtec_timer.sv */
/*
 * Dual 16-bit count-up timer/event counter with an AHB-Lite register
 * slave. Counter 0: timer, event count or pulse-width measurement.
 * Counter 1: timer on a 32768 Hz tick derived from the system clock.
 * Assumes hclk at 25 MHz, an external interrupt controller taking the
 * overflow pulses, and an external pin that may be asynchronous.
 */
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// (RULE1) Two independent 16-bit up counters; counter 0 has three modes.
// (RULE2) Counter 0 counts system clock over four, or the external pin.
// (RULE3) Counter 1 counts a 32768 Hz tick.
// (RULE4) Pulse-width mode counts the divided system clock, not pin edges.
// (RULE5) Event mode adds one per matching pin transition.
// (RULE6) Overflow past FFFF reloads preload, requests interrupt, keeps counting.
// (RULE7) Preload has no defined value after reset.
// (RULE8) Software clears preload for the full 16-bit range.
// (RULE9) Preload write while stopped also loads the live count.
// (RULE10) Preload write while running reaches the count at next overflow.
// (RULE11) Low-byte write only fills a holding buffer.
// (RULE12) High-byte write loads high byte and moves buffered low byte.
// (RULE13) Software writes low byte before high byte.
// (RULE14) High-byte read captures live low byte; software reads high first.
// (RULE15) Low-byte read returns the captured byte.
// (RULE16) Counter 0 mode in control bits 7:6; counter 1 timer only.
// (RULE17) Control bit 4 runs or stops the counter.
// (RULE18) Control bit 3 picks pin edge in event and pulse modes.
// (RULE19) Mode code 10 timer, 01 event, 11 pulse width.
// (RULE20) Edge bit low counts rising edges, high counts falling.
// (RULE21) Pulse mode counts between edges then clears its run bit.
// (RULE22) External pin is synchronised before edge detection.
// (RULE23) Each overflow gives a one-cycle interrupt request pulse.
module dtec_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic external_count_pin,
    output logic counter0_irq,
    output logic counter1_irq
);
    import dtec_pkg::*;

    // ==========================================================
    // Counter step
    // ==========================================================
    // Returns the overflow flag above the next count value
    function automatic logic [16:0] count_step(
        input logic [15:0] cnt,
        input logic [15:0] pre
    );
        count_step = (cnt == COUNT_FULL) ? {1'b1, pre} : {1'b0, cnt + 16'h0001};
    endfunction

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    logic dp_valid, next_dp_valid;
    logic dp_write, next_dp_write;
    logic [7:0] dp_addr, next_dp_addr;
    logic rd_done, next_rd_done;
    logic [31:0] rdata, next_rdata;
    logic rd_now, wr_now;
    logic [7:0] wbyte;
    logic wr_lo [2];
    logic wr_hi [2];
    logic wr_ctl [2];
    logic rd_lo [2];
    logic rd_hi [2];

    // Counter state, declared here for the read mux
    logic [15:0] count [2];
    logic [15:0] next_count [2];
    logic [15:0] preload [2];
    logic [15:0] next_preload [2];
    logic [7:0] wbuf [2];
    logic [7:0] next_wbuf [2];
    logic [7:0] rbuf [2];
    logic [7:0] next_rbuf [2];
    logic [7:0] ctrl [2];
    logic [7:0] next_ctrl [2];

    // Reads take one wait state because the read mux output is registered into rdata
    assign rd_now = dp_valid & ~dp_write & ~rd_done;
    assign wr_now = dp_valid & dp_write;
    assign hreadyout = ~rd_now;
    assign hresp = 1'b0;
    assign hrdata = rdata;
    assign wbyte = hwdata[7:0];

    // Address and data phase tracking
    always_comb begin
        next_dp_valid = dp_valid;
        next_dp_write = dp_write;
        next_dp_addr = dp_addr;
        next_rd_done = rd_now;
        if (hreadyout) begin
            next_dp_valid = hsel & htrans[1] & hready;
            next_dp_write = hwrite;
            next_dp_addr = haddr[7:0];
            next_rd_done = 1'b0;
        end
    end
    // Register strobes per counter
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wr_lo[i] = wr_now & (dp_addr == OFS_LO[i]);
            wr_hi[i] = wr_now & (dp_addr == OFS_HI[i]);
            wr_ctl[i] = wr_now & (dp_addr == OFS_CTL[i]);
            rd_lo[i] = rd_now & (dp_addr == OFS_LO[i]);
            rd_hi[i] = rd_now & (dp_addr == OFS_HI[i]);
        end
    end
    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = rdata;
        if (rd_now) begin
            next_rdata = 32'h0000_0000;
            for (int i = 0; i < 2; i++) begin
                if (dp_addr == OFS_LO[i]) begin
                    next_rdata[7:0] = rbuf[i]; // RULE15
                end
                if (dp_addr == OFS_HI[i]) begin
                    next_rdata[7:0] = count[i][15:8];
                end
                if (dp_addr == OFS_CTL[i]) begin
                    next_rdata[7:0] = ctrl[i] & CTL_MASK[i];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            rd_done <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            rd_done <= next_rd_done;
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Pin synchroniser, edge detect and clock ticks
    // ==========================================================
    logic pin_s1, pin_s2, pin_s3;
    logic pin_rise, pin_fall;
    logic [1:0] div, next_div;
    logic fast_tick;
    logic [ACC_W-1:0] acc, next_acc;
    logic [ACC_W-1:0] acc_sum;
    logic slow_tick;
    // Edges come from the second and third stages only
    assign pin_rise = pin_s2 & ~pin_s3; // RULE22
    assign pin_fall = ~pin_s2 & pin_s3;

    // System clock over four, and a 32768 Hz fractional tick
    assign fast_tick = (div == FAST_DIV_LAST); // RULE2
    assign acc_sum = acc + SLOW_HZ;
    assign slow_tick = (acc_sum >= SYS_HZ); // RULE3

    always_comb begin
        next_div = div + 2'h1;
        next_acc = acc_sum;
        if (slow_tick) begin
            next_acc = acc_sum - SYS_HZ;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
            div <= 2'h0;
            acc <= '0;
        end else begin
            pin_s1 <= external_count_pin; // RULE22
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            div <= next_div;
            acc <= next_acc;
        end
    end

    // ==========================================================
    // Counters
    // ==========================================================
    logic [1:0] mode0;
    logic run [2];
    logic esel0;
    logic act_edge, pw_start, pw_end, pw_stop;
    logic tick [2];
    logic ovf [2];
    logic [16:0] step [2];
    dtec_pw_e pw_state, next_pw_state;
    assign mode0 = ctrl[0][CTL_MODE_HI:CTL_MODE_LO]; // RULE16
    assign run[0] = ctrl[0][CTL_RUN]; // RULE17
    assign run[1] = ctrl[1][CTL_RUN];
    assign esel0 = ctrl[0][CTL_EDGE]; // RULE18
    assign act_edge = esel0 ? pin_fall : pin_rise; // RULE20
    assign pw_start = esel0 ? pin_rise : pin_fall;
    assign pw_end = esel0 ? pin_fall : pin_rise;

    // Count enables; mode 00 leaves counter 0 idle
    always_comb begin
        case (mode0) // RULE19
            MODE_TIMER: tick[0] = run[0] & fast_tick;
            MODE_EVENT: tick[0] = run[0] & act_edge; // RULE5
            MODE_PULSE: tick[0] = run[0] & fast_tick & (pw_state == PW_MEASURE); // RULE4
            default: tick[0] = 1'b0;
        endcase
        tick[1] = run[1] & slow_tick; // RULE1
    end
    // Pulse-width sequencer: wait for start edge, count, stop on return
    always_comb begin
        next_pw_state = pw_state;
        pw_stop = 1'b0;
        if (!(run[0] && mode0 == MODE_PULSE)) begin
            next_pw_state = PW_WAIT;
        end else begin
            case (pw_state)
                PW_WAIT: begin
                    if (pw_start) begin
                        next_pw_state = PW_MEASURE;
                    end
                end
                PW_MEASURE: begin
                    if (pw_end) begin
                        next_pw_state = PW_WAIT;
                        pw_stop = 1'b1; // RULE21
                    end
                end
                default: next_pw_state = PW_WAIT;
            endcase
        end
    end
    // Count, preload, byte buffers and control per counter
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            step[i] = count_step(count[i], preload[i]);
            ovf[i] = tick[i] & step[i][16]; // RULE6
            next_count[i] = count[i];
            next_preload[i] = preload[i];
            next_wbuf[i] = wbuf[i];
            next_rbuf[i] = rbuf[i];
            next_ctrl[i] = ctrl[i];
            if (wr_lo[i]) begin
                next_wbuf[i] = wbyte; // RULE11
            end
            if (wr_hi[i]) begin
                next_preload[i] = {wbyte, wbuf[i]}; // RULE12
            end
            if (wr_hi[i] && !run[i]) begin
                next_count[i] = {wbyte, wbuf[i]}; // RULE9
            end else if (tick[i]) begin
                next_count[i] = step[i][15:0]; // RULE10
            end
            if (rd_hi[i]) begin
                next_rbuf[i] = count[i][7:0]; // RULE14
            end
            if (wr_ctl[i]) begin
                next_ctrl[i] = wbyte & CTL_MASK[i];
            end
        end
        if (pw_stop && !wr_ctl[0]) begin
            next_ctrl[0][CTL_RUN] = 1'b0; // RULE21
        end
    end
    // Preload carries no reset
    always_ff @(posedge hclk) begin
        preload <= next_preload; // RULE7
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '{COUNT_RESET, COUNT_RESET};
            wbuf <= '{BUF_RESET, BUF_RESET};
            rbuf <= '{BUF_RESET, BUF_RESET};
            ctrl <= '{CTL_RESET, CTL_RESET};
            pw_state <= PW_WAIT;
            counter0_irq <= 1'b0;
            counter1_irq <= 1'b0;
        end else begin
            count <= next_count;
            wbuf <= next_wbuf;
            rbuf <= next_rbuf;
            ctrl <= next_ctrl;
            pw_state <= next_pw_state;
            counter0_irq <= ovf[0]; // RULE23
            counter1_irq <= ovf[1];
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking dtec_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Divided clock ticks exactly every fourth cycle
    property p_prescale;
        fast_tick |=> !fast_tick [*3] ##1 fast_tick;
    endproperty
    a_prescale: assert property (p_prescale) // RULE2
        else $error("divide-by-four tick spacing wrong");
    // Overflow reloads the preload and pulses the request
    property p_overflow;
        ovf[0] |=> counter0_irq && count[0] == $past(preload[0]);
    endproperty
    a_overflow: assert property (p_overflow) // RULE6
        else $error("counter 0 overflow did not reload");
    // Request lasts one cycle
    property p_irq_pulse;
        counter1_irq |=> !counter1_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) // RULE23
        else $error("counter 1 request longer than one cycle");
    // Event mode steps by one per active edge
    property p_event;
        run[0] && mode0 == MODE_EVENT && act_edge && count[0] != COUNT_FULL && !wr_hi[0]
            |=> count[0] == $past(count[0]) + 16'h0001;
    endproperty
    a_event: assert property (p_event) // RULE5
        else $error("event count did not step by one");
    // High-byte write while stopped loads the live count
    property p_copy_off;
        wr_hi[0] && !run[0] |=> count[0] == {$past(wbyte), $past(wbuf[0])};
    endproperty
    a_copy_off: assert property (p_copy_off) // RULE9
        else $error("stopped counter not loaded by write");
    // High-byte write while running leaves the count alone
    property p_hold_on;
        wr_hi[1] && run[1] && !tick[1] |=> count[1] == $past(count[1]);
    endproperty
    a_hold_on: assert property (p_hold_on) // RULE10
        else $error("running counter changed by preload write");
    // Low-byte write only fills the buffer; preload has no reset, so watch the count
    property p_low_buffered;
        wr_lo[0] && !tick[0] |=> count[0] == $past(count[0]) && wbuf[0] == $past(wbyte);
    endproperty
    a_low_buffered: assert property (p_low_buffered) // RULE11
        else $error("low-byte write reached the count");
    // High-byte read captures the live low byte
    property p_rd_capture;
        rd_hi[0] |=> rbuf[0] == $past(count[0][7:0]);
    endproperty
    a_rd_capture: assert property (p_rd_capture) // RULE14
        else $error("high-byte read did not capture low byte");
    // Low-byte read returns the captured byte
    property p_rd_low;
        rd_lo[1] |=> hrdata == {24'h000000, $past(rbuf[1])};
    endproperty
    a_rd_low: assert property (p_rd_low) // RULE15
        else $error("low-byte read not from capture buffer");
    // Return edge in pulse mode clears the run bit
    property p_pw_stop;
        pw_state == PW_MEASURE && run[0] && mode0 == MODE_PULSE && pw_end && !wr_ctl[0]
            |=> !ctrl[0][CTL_RUN] ##1 pw_state == PW_WAIT;
    endproperty
    a_pw_stop: assert property (p_pw_stop) // RULE21
        else $error("pulse end did not stop counter 0");
    // Stopped counter 1 holds its value
    property p_c1_off;
        !run[1] && !wr_hi[1] |=> $stable(count[1]);
    endproperty
    a_c1_off: assert property (p_c1_off) // RULE17
        else $error("stopped counter 1 moved");
    // Read data phase has exactly one wait state
    property p_stall;
        rd_now |-> !hreadyout ##1 hreadyout;
    endproperty
    a_stall: assert property (p_stall)
        else $error("read wait state wrong");

    c_ovf0: cover property (ovf[0]);
    c_ovf1: cover property (ovf[1]);
    c_pw_done: cover property (pw_state == PW_MEASURE ##1 pw_state == PW_WAIT);
    c_event: cover property (tick[0] && mode0 == MODE_EVENT);

endmodule // dtec_timer

/* File: dtec_pin_src.sv */
/*
 * Far-side model: a source of events and pulses on the external timer pin.
 * Assumes the bench calls its task; the pin changes just after hclk edges.
 */
`timescale 1ns/1ps

module dtec_pin_src (
    input wire logic hclk,
    output logic pin
);
    // ==========================================================
    // Pin stimulus
    // ==========================================================
    initial pin = 1'b0;

    // Drive a level, then hold it for n cycles (at least two)
    task automatic drive(input logic v, input int n);
        @(posedge hclk);
        pin <= v;
        repeat (n) @(posedge hclk);
    endtask
endmodule // dtec_pin_src

/* File: test_dtec_timer.sv */
/*
 * Self-checking bench for the dual timer/event counter.
 * Assumes one slave on AHB-Lite with hready tied to hreadyout.
 */
`timescale 1ns/1ps

module test_dtec_timer;
    import dtec_pkg::*;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin;
    logic counter0_irq;
    logic counter1_irq;
    logic prev0 = 1'b0;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n_irq0 = 0;
    int base, t0, t1, t2;
    logic [31:0] v, v2;

    // ==========================================================
    // Clock, design and partner
    // ==========================================================
    always #20 hclk = ~hclk;

    dtec_timer dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(3'h2),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .external_count_pin(pin),
        .counter0_irq(counter0_irq),
        .counter1_irq(counter1_irq)
    );

    dtec_pin_src src (
        .hclk(hclk),
        .pin(pin)
    );

    // Cycle count, counter 0 overflow pulses and their one-cycle width
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        prev0 <= counter0_irq;
        if (counter0_irq === 1'b1) begin
            n_irq0++;
        end
        if (counter0_irq === 1'b1 && prev0 === 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: irq 1 then %h", $time, counter0_irq);
        end
    end

    // ==========================================================
    // Compare and bus tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h range %h %h", $time, got, lo, hi);
        end
    endtask

    // One single AHB-Lite transfer; waits for hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 8'h00, rd);
        chk(rd, {24'h0, exp});
    endtask

    // Low byte first, then high byte
    task automatic wr16(input int i, input logic [15:0] d);
        wr(OFS_LO[i], d[7:0]);
        wr(OFS_HI[i], d[15:8]);
    endtask

    // High byte first, then the captured low byte
    task automatic rd16(input int i, input logic [15:0] exp);
        rdc(OFS_HI[i], exp[15:8]);
        rdc(OFS_LO[i], exp[7:0]);
    endtask

    task automatic wirq(input int k, output int t);
        do @(posedge hclk); while (((k == 0) ? counter0_irq : counter1_irq) !== 1'b1);
        t = cyc;
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 30000 cycles of the tests
    initial begin
        repeat (80000) @(posedge hclk);
        err_total++;
        stop_test;
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and an unmapped word
        rdc(OFS_CTL[0], CTL_RESET);
        rdc(OFS_CTL[1], CTL_RESET);
        rd16(0, COUNT_RESET);
        rdc(8'h18, 8'h00);
        chk({31'h0, hresp}, 32'h0);
        $display("test 1 done");
        // Buffered low byte, loaded by the high-byte write while stopped
        wr(OFS_LO[0], 8'h34);
        rd16(0, 16'h0000);
        wr(OFS_HI[0], 8'h12);
        rd16(0, 16'h1234);
        $display("test 2 done");
        // Writable control bits
        wr(OFS_CTL[0], 8'hff);
        rdc(OFS_CTL[0], 8'hd8);
        wr(OFS_CTL[0], 8'h00);
        wr(OFS_CTL[1], 8'hff);
        rdc(OFS_CTL[1], 8'h10);
        wr(OFS_CTL[1], 8'h00);
        $display("test 3 done");
        // Event mode, rising edges, overflow and reload
        wr16(0, 16'hfffe);
        base = n_irq0;
        wr(OFS_CTL[0], 8'h50);
        repeat (2) begin
            src.drive(1'b1, 8);
            src.drive(1'b0, 8);
        end
        wr(OFS_CTL[0], 8'h40);
        rd16(0, 16'hfffe);
        chk(n_irq0 - base, 1);
        $display("test 4 done");
        // Event mode, falling edge selected
        wr16(0, 16'h0000);
        wr(OFS_CTL[0], 8'h58);
        src.drive(1'b1, 8);
        rd16(0, 16'h0000);
        src.drive(1'b0, 8);
        rd16(0, 16'h0001);
        wr(OFS_CTL[0], 8'h00);
        $display("test 5 done");
        // Timer mode; preload written while running waits for overflow
        wr16(0, 16'hfff0);
        t0 = cyc;
        wr(OFS_CTL[0], 8'h90);
        wr16(0, 16'hff00);
        wirq(0, t1);
        wirq(0, t2);
        chk_rng(t1 - t0, 60, 76);
        chk(t2 - t1, 1024);
        wr(OFS_CTL[0], 8'h00);
        $display("test 6 done");
        // Pulse width: low pulse of 400 cycles, run bit clears itself
        src.drive(1'b1, 4);
        wr16(0, 16'h0000);
        wr(OFS_CTL[0], 8'hd0);
        src.drive(1'b0, 400);
        src.drive(1'b1, 8);
        rdc(OFS_CTL[0], 8'hc0);
        rdc(OFS_HI[0], 8'h00);
        ahb(1'b0, OFS_LO[0], 8'h00, v);
        chk_rng(v, 98, 102);
        src.drive(1'b0, 40);
        src.drive(1'b1, 8);
        rdc(OFS_HI[0], 8'h00);
        ahb(1'b0, OFS_LO[0], 8'h00, v2);
        chk(v2, v);
        $display("test 7 done");
        // Counter 1 on the 32768 Hz tick, sixteen ticks per overflow
        wr16(1, 16'hfff0);
        rd16(1, 16'hfff0);
        wr(OFS_CTL[1], 8'h10);
        wr16(1, 16'hfff0);
        wirq(1, t1);
        wirq(1, t2);
        chk_rng(t2 - t1, 12206, 12208);
        wr(OFS_CTL[1], 8'h00);
        $display("test 8 done");
        stop_test;
    end
endmodule // test_dtec_timer
